/* pds_phase_step.sv */
// Dynamic phase stepper: scan clock handshake, settle timer, AXI4-Lite regs
// Functional notes
// - Selector 000 moves all output dividers, 001 the feedback divider, 010 to 110 output dividers 0 to 4, and 111 moves nothing.
// - Each step request pulse that rises while idle gives exactly one increment, however long it is held.
// - The done flag falls on a scan clock rising edge when a shift starts.
// - The done flag rises from the internal settle timing once the shift is finished.
// - Direction and selector are sampled on the scan clock.
// - The scan clock is a free-running clock, separate from the core clock, and clocks the link logic.
// - The step sequence repeats without limit, one increment per pass.
module pds_phase_step (
    input wire logic clk,
    input wire logic rst,
    input wire logic scanclk,
    input wire logic phasestep,
    input wire logic phaseupdown,
    input wire logic [2:0] phase_counter_select,
    output logic phasedone,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
`include "pds_regs.svh"

    localparam int SETTLE_CYC_RAW =
        (`PDS_SETTLE_NS + `PDS_CLK_NS - 1) / `PDS_CLK_NS;
    // Floor at one so a tiny settle time still waits a cycle
    localparam int SETTLE_CYC = (SETTLE_CYC_RAW < 1) ? 1 : SETTLE_CYC_RAW;
    localparam logic [`PDS_SETTLE_W-1:0] SETTLE_RST =
        `PDS_SETTLE_W'(SETTLE_CYC);
    localparam logic [`PDS_PHASE_W-1:0] PH_ONE = `PDS_PHASE_W'(1);

    pds_pkg::pds_scan_s s_r;
    pds_pkg::pds_scan_s s_nxt;
    pds_pkg::pds_core_s c_r;
    pds_pkg::pds_core_s c_nxt;

    pds_sync_if #(.W(1)) rst_if ();
    pds_sync_if #(.W(1)) req_if ();
    pds_sync_if #(.W(1)) ack_if ();

    // Reset reaches the link logic through its own synchroniser
    assign rst_if.d = rst;
    assign req_if.d = s_r.req_tog;
    assign ack_if.d = c_r.ack_tog;

    pds_sync #(.W(1)) u_rst_sync (
        .clk(scanclk),
        .rst(1'b0),
        .s(rst_if)
    );

    pds_sync #(.W(1)) u_req_sync (
        .clk(clk),
        .rst(rst),
        .s(req_if)
    );

    pds_sync #(.W(1)) u_ack_sync (
        .clk(scanclk),
        .rst(rst_if.q),
        .s(ack_if)
    );

    // Link side, on the free-running scan clock
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.step_prev = phasestep;
        // Start only on a fresh rising step while idle
        // A step seen while busy is dropped, never queued
        if (phasestep && !s_r.step_prev && s_r.done)
        begin
            s_nxt.done = 1'b0;
            s_nxt.req_tog = ~s_r.req_tog;
            s_nxt.dir = phaseupdown;
            s_nxt.sel = phase_counter_select;
        end
        else if (ack_if.q != s_r.ack_seen)
        begin
            // Completion returns as a toggle, safe across the clocks
            s_nxt.ack_seen = ack_if.q;
            s_nxt.done = 1'b1;
        end
        if (rst_if.q)
        begin
            s_nxt = '0;
            s_nxt.done = 1'b1;
        end
    end

    always_ff @(posedge scanclk)
    begin
        s_r <= s_nxt;
    end

    assign phasedone = s_r.done;

    // Core side: register slave and settle timer
    always_comb
    begin
        logic [7:0] roff;
        logic [7:0] woff;
        logic rhit_ph;
        logic whit;
        logic [2:0] ridx;
        logic [`PDS_PHASE_W-1:0] pv;
        roff = '0;
        woff = '0;
        rhit_ph = 1'b0;
        whit = 1'b0;
        ridx = '0;
        pv = '0;
        c_nxt = c_r;

        if (s_axi_awvalid && c_r.awready)
        begin
            c_nxt.awready = 1'b0;
            c_nxt.aw_got = 1'b1;
            c_nxt.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && c_r.wready)
        begin
            c_nxt.wready = 1'b0;
            c_nxt.w_got = 1'b1;
            c_nxt.wdata = s_axi_wdata;
            c_nxt.wstrb = s_axi_wstrb;
        end

        // Both halves held; answer one cycle later
        if (c_r.aw_got && c_r.w_got && !c_r.bvalid)
        begin
            c_nxt.aw_got = 1'b0;
            c_nxt.w_got = 1'b0;
            c_nxt.bvalid = 1'b1;
            woff = c_r.awaddr - `PDS_ADDR_PHASE0;
            whit = (c_r.awaddr == `PDS_ADDR_CTRL) ||
                (c_r.awaddr == `PDS_ADDR_SETTLE) ||
                (c_r.awaddr == `PDS_ADDR_STATUS) ||
                (c_r.awaddr == `PDS_ADDR_COUNT) ||
                (c_r.awaddr >= `PDS_ADDR_PHASE0 &&
                 woff < `PDS_PHASE_SPAN && woff[1:0] == 2'h0);
            c_nxt.bresp = whit ? `PDS_RESP_OKAY : `PDS_RESP_SLVERR;
            if (c_r.awaddr == `PDS_ADDR_SETTLE)
            begin
                if (c_r.wstrb[0])
                begin
                    c_nxt.settle[7:0] = c_r.wdata[7:0];
                end
                if (c_r.wstrb[1])
                begin
                    c_nxt.settle[15:8] = c_r.wdata[15:8];
                end
            end
            // Clear comes first so a same-cycle step still lands
            if (c_r.awaddr == `PDS_ADDR_CTRL && c_r.wstrb[0] &&
                c_r.wdata[`PDS_CTRL_CLEAR_BIT])
            begin
                c_nxt.phase = '0;
                c_nxt.steps = '0;
                c_nxt.bad_sel = 1'b0;
            end
        end
        if (c_r.bvalid && s_axi_bready)
        begin
            c_nxt.bvalid = 1'b0;
            c_nxt.awready = 1'b1;
            c_nxt.wready = 1'b1;
        end

        if (s_axi_arvalid && c_r.arready)
        begin
            c_nxt.arready = 1'b0;
            c_nxt.rvalid = 1'b1;
            c_nxt.rresp = `PDS_RESP_OKAY;
            c_nxt.rdata = '0;
            roff = s_axi_araddr - `PDS_ADDR_PHASE0;
            ridx = roff[4:2];
            rhit_ph = s_axi_araddr >= `PDS_ADDR_PHASE0 &&
                roff < `PDS_PHASE_SPAN && roff[1:0] == 2'h0;
            if (rhit_ph)
            begin
                // Index only when in range; the spare codes hold no word
                pv = c_r.phase[ridx];
                c_nxt.rdata = {{(32-`PDS_PHASE_W){pv[`PDS_PHASE_W-1]}}, pv};
            end
            else if (s_axi_araddr == `PDS_ADDR_CTRL)
            begin
                c_nxt.rdata = '0;
            end
            else if (s_axi_araddr == `PDS_ADDR_SETTLE)
            begin
                c_nxt.rdata[`PDS_SETTLE_W-1:0] = c_r.settle;
            end
            else if (s_axi_araddr == `PDS_ADDR_STATUS)
            begin
                c_nxt.rdata[`PDS_ST_BUSY_BIT] = c_r.busy;
                c_nxt.rdata[`PDS_ST_DIR_BIT] = c_r.last_dir;
                c_nxt.rdata[`PDS_ST_BADSEL_BIT] = c_r.bad_sel;
                c_nxt.rdata[`PDS_ST_SEL_LSB +: 3] = c_r.last_sel;
            end
            else if (s_axi_araddr == `PDS_ADDR_COUNT)
            begin
                c_nxt.rdata = c_r.steps;
            end
            else
            begin
                c_nxt.rresp = `PDS_RESP_SLVERR;
            end
        end
        if (c_r.rvalid && s_axi_rready)
        begin
            c_nxt.rvalid = 1'b0;
            c_nxt.arready = 1'b1;
        end

        // Direction and selector are held stable by the link until ack
        if (req_if.q != c_r.req_seen)
        begin
            c_nxt.req_seen = req_if.q;
            c_nxt.busy = 1'b1;
            c_nxt.wait_cnt = c_r.settle;
            c_nxt.last_dir = s_r.dir;
            c_nxt.last_sel = s_r.sel;
        end
        else if (c_r.busy)
        begin
            if (c_r.wait_cnt > `PDS_SETTLE_W'(1))
            begin
                c_nxt.wait_cnt = c_r.wait_cnt - `PDS_SETTLE_W'(1);
            end
            else
            begin
                c_nxt.busy = 1'b0;
                c_nxt.ack_tog = ~c_r.ack_tog;
                c_nxt.steps = c_nxt.steps + 32'h1;
                if (c_r.last_sel == `PDS_SEL_NONE)
                begin
                    c_nxt.bad_sel = 1'b1;
                end
                for (int i = 0; i < `PDS_NUM_CNT; i++)
                begin
                    if ((c_r.last_sel == `PDS_SEL_ALL && i != 0) ||
                        (c_r.last_sel == 3'(i + 1)))
                    begin
                        if (c_r.last_dir)
                        begin
                            c_nxt.phase[i] = c_nxt.phase[i] + PH_ONE;
                        end
                        else
                        begin
                            c_nxt.phase[i] = c_nxt.phase[i] - PH_ONE;
                        end
                    end
                end
            end
        end

        if (rst)
        begin
            c_nxt = '0;
            c_nxt.settle = SETTLE_RST;
            c_nxt.awready = 1'b1;
            c_nxt.wready = 1'b1;
            c_nxt.arready = 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        c_r <= c_nxt;
    end

    assign s_axi_awready = c_r.awready;
    assign s_axi_wready = c_r.wready;
    assign s_axi_bvalid = c_r.bvalid;
    assign s_axi_bresp = c_r.bresp;
    assign s_axi_arready = c_r.arready;
    assign s_axi_rvalid = c_r.rvalid;
    assign s_axi_rdata = c_r.rdata;
    assign s_axi_rresp = c_r.rresp;
endmodule // pds_phase_step

/* pds_regs.svh */
// Register map, field positions and timing constants of the phase stepper
`ifndef PDS_REGS_SVH
`define PDS_REGS_SVH

`define PDS_CLK_NS 20
`define PDS_SETTLE_NS 200
`define PDS_PHASE_W 16
`define PDS_SETTLE_W 16
`define PDS_NUM_CNT 6

`define PDS_ADDR_CTRL 8'h00
`define PDS_ADDR_SETTLE 8'h04
`define PDS_ADDR_STATUS 8'h08
`define PDS_ADDR_COUNT 8'h0c
`define PDS_ADDR_PHASE0 8'h10
`define PDS_PHASE_SPAN 8'h18

`define PDS_CTRL_CLEAR_BIT 0
`define PDS_ST_BUSY_BIT 0
`define PDS_ST_DIR_BIT 1
`define PDS_ST_BADSEL_BIT 2
`define PDS_ST_SEL_LSB 4

`define PDS_SEL_ALL 3'h0
`define PDS_SEL_FB 3'h1
`define PDS_SEL_NONE 3'h7

`define PDS_RESP_OKAY 2'h0
`define PDS_RESP_SLVERR 2'h2

`endif

/* pds_pkg.sv */
// State types of the phase stepper
package pds_pkg;
`include "pds_regs.svh"

    typedef struct packed {
        logic step_prev;
        logic done;
        logic req_tog;
        logic ack_seen;
        logic dir;
        logic [2:0] sel;
    } pds_scan_s;

    typedef struct packed {
        logic req_seen;
        logic busy;
        logic [`PDS_SETTLE_W-1:0] wait_cnt;
        logic ack_tog;
        logic [`PDS_SETTLE_W-1:0] settle;
        logic [31:0] steps;
        logic bad_sel;
        logic last_dir;
        logic [2:0] last_sel;
        logic [`PDS_NUM_CNT-1:0][`PDS_PHASE_W-1:0] phase;
        logic awready;
        logic wready;
        logic arready;
        logic aw_got;
        logic w_got;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } pds_core_s;
endpackage

/* pds_sync_if.sv */
// Carrier between a crossing source and its synchroniser
interface pds_sync_if #(parameter int W = 1);
    logic [W-1:0] d;
    logic [W-1:0] q;
    modport src (output d, input q);
    modport sync (input d, output q);
endinterface

/* pds_sync.sv */
// Two flip-flop synchroniser into the destination clock
module pds_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst,
    pds_sync_if.sync s
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] q;
    } pds_sync_s;

    pds_sync_s st_r;
    pds_sync_s st_nxt;

    // First stage feeds only the second
    always_comb
    begin
        st_nxt.meta = s.d;
        st_nxt.q = st_r.meta;
        if (rst)
        begin
            st_nxt = '0;
        end
    end

    always_ff @(posedge clk)
    begin
        st_r <= st_nxt;
    end

    assign s.q = st_r.q;
endmodule // pds_sync

/* pds_checker_properties.sv */
// Port checks of the phase stepper
module pds_checker (
    input wire logic clk,
    input wire logic rst,
    input wire logic scanclk,
    input wire logic phasestep,
    input wire logic phasedone,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    logic step_r;
    logic take;
    always_ff @(posedge scanclk)
    begin
        step_r <= phasestep;
    end
    // Only a fresh rising step while idle starts a shift
    assign take = phasestep && !step_r && phasedone;
    sequence s_busy;
        !phasedone [*2];
    endsequence
    property p_done_fall;
        @(posedge scanclk) disable iff (rst) take |=> s_busy;
    endproperty
    property p_done_back;
        @(posedge scanclk) disable iff (rst)
            $fell(phasedone) |-> ##[3:64] phasedone;
    endproperty
    property p_no_fall;
        @(posedge scanclk) disable iff (rst) phasedone && !take |=> phasedone;
    endproperty
    property p_b_lat;
        @(posedge clk) disable iff (rst) s_axi_awvalid && s_axi_awready &&
            s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
    endproperty
    property p_b_hold;
        @(posedge clk) disable iff (rst) s_axi_bvalid && !s_axi_bready
            |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    property p_r_lat;
        @(posedge clk) disable iff (rst)
            s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
    endproperty
    property p_r_hold;
        @(posedge clk) disable iff (rst) s_axi_rvalid && !s_axi_rready
            |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    property p_aw_block;
        @(posedge clk) disable iff (rst)
            s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_done_fall: assert property (p_done_fall)
        else $error("done flag did not fall on a new step");
    a_done_back: assert property (p_done_back)
        else $error("done flag did not return in time");
    a_no_fall: assert property (p_no_fall)
        else $error("done flag fell without a new step");
    a_b_lat: assert property (p_b_lat)
        else $error("write response late");
    a_b_hold: assert property (p_b_hold)
        else $error("write response dropped early");
    a_r_lat: assert property (p_r_lat)
        else $error("read data late");
    a_r_hold: assert property (p_r_hold)
        else $error("read data changed while waiting");
    a_aw_block: assert property (p_aw_block)
        else $error("write accepted while response pending");
endmodule // pds_checker

bind pds_phase_step pds_checker u_chk (.clk, .rst, .scanclk, .phasestep,
    .phasedone, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready);

/* pds_user_model.sv */
// Fabric-side user logic that steps the phase
module pds_user_model (
    input wire logic scanclk,
    input wire logic phasedone,
    output logic phasestep,
    output logic phaseupdown,
    output logic [2:0] phase_counter_select
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        phasestep = 1'b0;
        phaseupdown = 1'b0;
        phase_counter_select = 3'h0;
    end
    task automatic shift(input logic d, input logic [2:0] s, input int extra);
        @(posedge scanclk);
        phaseupdown <= d;
        phase_counter_select <= s;
        @(posedge scanclk);
        phasestep <= 1'b1;
        repeat (2) @(posedge scanclk);
        while (phasedone) @(posedge scanclk);
        repeat (extra) @(posedge scanclk);
        phasestep <= 1'b0;
        // Stale lines show junk so late sampling is caught
        phaseupdown <= ~d;
        phase_counter_select <= ~s;
        while (!phasedone) @(posedge scanclk);
    endtask
endmodule // pds_user_model

/* tb_top.sv */
// Self-checking bench of the phase stepper
`include "pds_regs.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst, scanclk, phasedone, phasestep, phaseupdown;
    logic [2:0] phase_counter_select, s;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready, d;
    logic signed [15:0] ph [6];
    logic [5:0] m;
    int num_errors, cmp_count, i, k;
    integer seed;
    pds_phase_step dut (.clk, .rst, .scanclk, .phasestep, .phaseupdown,
        .phase_counter_select, .phasedone, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    pds_user_model u_user (.scanclk, .phasedone, .phasestep, .phaseupdown,
        .phase_counter_select);
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Free running, phase unrelated to clk
    initial
    begin
        scanclk = 1'b0;
        #7;
        forever #16 scanclk = ~scanclk;
    end
    function automatic logic [5:0] tgt(input logic [2:0] sel);
        case (sel)
            3'h0: return 6'h3e;
            3'h1: return 6'h01;
            3'h7: return 6'h00;
            default: return 6'h01 << (sel - 3'h1);
        endcase
    endfunction
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Ready raised only on seeing valid, so the hold path is exercised
    task wr(input logic [7:0] a, input logic [31:0] v);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        forever
        begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && s_axi_bready)
            begin
                rsp = s_axi_bresp;
                s_axi_bready <= 1'b0;
                break;
            end
            if (s_axi_bvalid) s_axi_bready <= 1'b1;
        end
    endtask
    task rdt(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        forever
        begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && s_axi_rready)
            begin
                rd = s_axi_rdata;
                rsp = s_axi_rresp;
                s_axi_rready <= 1'b0;
                break;
            end
            if (s_axi_rvalid) s_axi_rready <= 1'b1;
        end
    endtask
    task chk_ph;
        for (k = 0; k < 6; k++)
        begin
            rdt(`PDS_ADDR_PHASE0 + 8'(4 * k));
            chk(rd, {{16{ph[k][15]}}, ph[k]});
        end
    endtask
    task end_sim;
        $display("errors=%0d compares=%0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (50000) @(posedge clk);
        num_errors++;
        end_sim;
    end
    initial
    begin
        seed = 32'h6a99;
        rst = 1'b1;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hf;
        foreach (ph[k]) ph[k] = 16'sh0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge scanclk);
        @(posedge clk);
        rdt(`PDS_ADDR_SETTLE);
        chk(rd, 32'ha);
        chk_ph;
        rdt(8'h40);
        chk({rd[29:0], rsp}, 32'h2);
        wr(8'h40, 32'h1);
        chk(rsp, `PDS_RESP_SLVERR);
        wr(`PDS_ADDR_COUNT, 32'h5);
        rdt(`PDS_ADDR_COUNT);
        chk({rd[29:0], rsp}, 32'h0);
        wr(`PDS_ADDR_SETTLE, 32'h1);
        rdt(`PDS_ADDR_SETTLE);
        chk(rd, 32'h1);
        for (i = 0; i < 30; i++)
        begin
            if (i == 15) wr(`PDS_ADDR_SETTLE, 32'hf);
            d = 1'($random(seed));
            s = (i < 7) ? 3'(i) : 3'($unsigned($random(seed)) % 7);
            u_user.shift(d, s, (i % 4 == 0) ? 12 : i % 3);
            m = tgt(s);
            for (k = 0; k < 6; k++)
                if (m[k]) ph[k] = ph[k] + (d ? 16'sh1 : -16'sh1);
            @(posedge clk);
            rdt(`PDS_ADDR_COUNT);
            chk(rd, 32'(i + 1));
            rdt(`PDS_ADDR_STATUS);
            chk(rd & 32'h77, {25'h0, s, 2'b0, d, 1'b0});
            chk_ph;
        end
        u_user.shift(1'b1, `PDS_SEL_NONE, 0);
        @(posedge clk);
        rdt(`PDS_ADDR_STATUS);
        chk(rd[2], 1'b1);
        chk_ph;
        rdt(`PDS_ADDR_COUNT);
        chk(rd, 32'h1f);
        wr(`PDS_ADDR_CTRL, 32'h1);
        rdt(`PDS_ADDR_STATUS);
        chk(rd[2], 1'b0);
        rdt(`PDS_ADDR_COUNT);
        chk(rd, 32'h0);
        foreach (ph[k]) ph[k] = 16'sh0;
        chk_ph;
        end_sim;
    end
endmodule // tb_top
